// ===== common/cgot_params.svh
`ifndef CGOT_PARAMS_SVH
`define CGOT_PARAMS_SVH
// table geometry
`define CGOT_NCOL          16
`define CGOT_COL_W         4
// register byte offsets
`define CGOT_ADR_MODE      8'h00
`define CGOT_ADR_COL       8'h04
`define CGOT_ADR_GAIN      8'h08
`define CGOT_ADR_OFS       8'h0C
`define CGOT_ADR_REVERT    8'h10
`define CGOT_ADR_PERSIST   8'h14
`define CGOT_ADR_STATUS    8'h18
// status bit positions
`define CGOT_ST_BUSY       0
`define CGOT_ST_SAVED      1
`define CGOT_ST_OFS_ERR    2
`define CGOT_ST_ACC_ERR    3
// coefficient formats and reset values
`define CGOT_OFS_STEP_BITS 5
`define CGOT_GAIN_UNITY    16'h1000
`define CGOT_GAIN_FRAC     12
`define CGOT_OFS_ZERO      16'h0000
`define CGOT_PIX_MAX       16'hFFFF
`define CGOT_MODE_RST      2'h0
`define CGOT_COL_RST       4'h0
`endif

// ===== common/cgot_pkg.sv
`include "cgot_params.svh"
package cgot_pkg;
  typedef enum logic [1:0] {
    CGOT_FACTORY = 2'h0,
    CGOT_USER    = 2'h1,
    CGOT_CALIB   = 2'h2
  } cgot_mode_t;

  typedef enum logic [2:0] {
    CGOT_IDLE  = 3'h1,
    CGOT_ACC   = 3'h2,
    CGOT_ACKED = 3'h4
  } cgot_bus_st_t;

  typedef struct packed {
    logic [15:0] gain;
    logic [15:0] offset;
  } cgot_coeff_t;

  typedef struct packed {
    logic                   valid;
    logic [`CGOT_COL_W-1:0] col;
    logic [15:0]            data;
  } cgot_pix_t;
endpackage : cgot_pkg

// ===== src/cgot_mem.sv
`timescale 1ns/10ps
`include "cgot_params.svh"
module cgot_mem
  import cgot_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   we_i,
  input  wire logic [`CGOT_COL_W-1:0] waddr_i,
  input  wire cgot_coeff_t            wdata_i,
  input  wire logic [`CGOT_COL_W-1:0] raddr_a_i,
  output cgot_coeff_t                 rdata_a_o,
  input  wire logic [`CGOT_COL_W-1:0] raddr_b_i,
  output cgot_coeff_t                 rdata_b_o
);
  cgot_coeff_t mem_reg [`CGOT_NCOL];

  // read before write: a same-edge read returns the old entry
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
    rdata_a_o <= mem_reg[raddr_a_i];
    rdata_b_o <= mem_reg[raddr_b_i];
  end
endmodule : cgot_mem

// ===== src/cgot_top.sv
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
`include "cgot_params.svh"
// Behaviour
// - coefficients reachable only in calibration mode
// - mode selector: factory, user or calibration
// - column selector picks column, resets to zero
// - gain access hits selected column's entry
// - 16-bit offset access hits selected column
// - revert restores last saved table
// - nothing saved: revert loads neutral coefficients
// - persist stores user table to retained memory; here reset clears the saved flag, so the saved table is dropped
// - persist overwrites the single saved table
// - pixel = (raw + offset) times gain
// - calibration forces correction off
// - factory follows gain level, user does not
// - offset not multiple of step is rejected
module cgot_top
  import cgot_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  input  wire logic        correction_on_i,
  input  wire logic [1:0]  gain_level_i,
  input  wire cgot_pix_t   pix_i,
  output cgot_pix_t        pix_o
);
  localparam cgot_coeff_t NEUTRAL = '{gain: `CGOT_GAIN_UNITY, offset: `CGOT_OFS_ZERO};

  cgot_bus_st_t           st_reg;
  cgot_mode_t             mode_reg;
  logic [`CGOT_COL_W-1:0] col_reg;
  logic                   ofs_err_reg;
  logic                   acc_err_reg;
  logic                   saved_valid_reg;
  logic                   copy_busy_reg;
  logic                   copy_persist_reg;
  logic [`CGOT_COL_W:0]   rd_idx_reg;
  logic                   wr_pend_reg;
  logic [`CGOT_COL_W-1:0] wr_idx_reg;
  cgot_pix_t              p1_reg;
  logic [1:0]             lvl_reg;
  cgot_coeff_t            ua;
  cgot_coeff_t            ub;
  cgot_coeff_t            sa;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire logic [31:0] wmask;
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b +: 8] = {8{sel_i[b]}};
    end
  endgenerate

  wire logic [31:0] wdata    = dat_i & wmask;
  wire logic        take     = cyc_i & stb_i & (st_reg == CGOT_IDLE) & ~copy_busy_reg;
  wire logic        acc      = st_reg == CGOT_ACC;
  wire logic        hit_mode = adr_i == `CGOT_ADR_MODE;
  wire logic        hit_col  = adr_i == `CGOT_ADR_COL;
  wire logic        hit_gain = adr_i == `CGOT_ADR_GAIN;
  wire logic        hit_ofs  = adr_i == `CGOT_ADR_OFS;
  wire logic        hit_rev  = adr_i == `CGOT_ADR_REVERT;
  wire logic        hit_per  = adr_i == `CGOT_ADR_PERSIST;
  wire logic        hit_stat = adr_i == `CGOT_ADR_STATUS;
  wire logic        is_calib = mode_reg == CGOT_CALIB;
  wire logic        unmapped = ~(hit_mode | hit_col | hit_gain | hit_ofs | hit_rev
                                 | hit_per | hit_stat);
  wire logic        tbl_hit  = hit_gain | hit_ofs | hit_rev | hit_per;
  wire logic        ofs_bad  = |wdata[`CGOT_OFS_STEP_BITS-1:0];
  wire logic        mode_bad = (wdata[1:0] == 2'h3) | (|wdata[31:2]);
  wire logic        col_bad  = |wdata[31:`CGOT_COL_W];
  // the table group is locked outside calibration, reads and writes alike
  wire logic        bad      = unmapped | (tbl_hit & ~is_calib)
                               | (we_i & hit_ofs & ofs_bad)
                               | (we_i & hit_mode & mode_bad)
                               | (we_i & hit_col & col_bad);
  wire logic        wr_ok    = acc & we_i & ~bad;
  wire logic        coeff_wr = wr_ok & (hit_gain | hit_ofs);
  wire logic        start    = wr_ok & (hit_rev | hit_per);
  wire logic [3:0]  stat     = {acc_err_reg, ofs_err_reg, saved_valid_reg, copy_busy_reg};
  wire logic [31:0] rd_mux   = hit_mode ? 32'(mode_reg) :
                               hit_col  ? 32'(col_reg) :
                               (hit_gain & is_calib) ? 32'(ua.gain) :
                               (hit_ofs & is_calib)  ? 32'(ua.offset) :
                               hit_stat ? 32'(stat) : 32'h0000_0000;
  wire logic        ofs_set  = acc & we_i & hit_ofs & ofs_bad & is_calib;
  wire logic        acc_set  = acc & bad;
  wire logic        stat_wr  = wr_ok & hit_stat;

  ////////////////////////////////////////////////////////////////////////////
  // bus state machine and control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= CGOT_IDLE;
      ack_o  <= 1'b0;
      err_o  <= 1'b0;
      dat_o  <= 32'h0000_0000;
    end else begin
      case (st_reg)
        CGOT_IDLE: begin
          if (take) begin
            st_reg <= CGOT_ACC;
          end
        end
        CGOT_ACC: begin
          st_reg <= CGOT_ACKED;
          ack_o  <= ~bad;
          err_o  <= bad;
          dat_o  <= (we_i | bad) ? 32'h0000_0000 : rd_mux;
        end
        default: begin
          st_reg <= CGOT_IDLE;
          ack_o  <= 1'b0;
          err_o  <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg    <= cgot_mode_t'(`CGOT_MODE_RST);
      col_reg     <= `CGOT_COL_RST;
      ofs_err_reg <= 1'b0;
      acc_err_reg <= 1'b0;
    end else begin
      if (wr_ok & hit_mode) begin
        mode_reg <= cgot_mode_t'(wdata[1:0]);
      end
      if (wr_ok & hit_col) begin
        col_reg <= wdata[`CGOT_COL_W-1:0];
      end
      // a new error in the clearing cycle survives
      ofs_err_reg <= ofs_set | (ofs_err_reg & ~(stat_wr & wdata[`CGOT_ST_OFS_ERR]));
      acc_err_reg <= acc_set | (acc_err_reg & ~(stat_wr & wdata[`CGOT_ST_ACC_ERR]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // table copy engine; reset runs a revert so the user table starts neutral
  wire logic rd_more = rd_idx_reg != (`CGOT_COL_W+1)'(`CGOT_NCOL);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      copy_busy_reg    <= 1'b1;
      copy_persist_reg <= 1'b0;
      rd_idx_reg       <= '0;
      wr_pend_reg      <= 1'b0;
      wr_idx_reg       <= '0;
      saved_valid_reg  <= 1'b0;
    end else if (start) begin
      copy_busy_reg    <= 1'b1;
      copy_persist_reg <= hit_per;
      rd_idx_reg       <= '0;
      wr_pend_reg      <= 1'b0;
      saved_valid_reg  <= saved_valid_reg | hit_per;
    end else if (copy_busy_reg) begin
      copy_busy_reg <= rd_more;
      wr_pend_reg   <= rd_more;
      wr_idx_reg    <= rd_idx_reg[`CGOT_COL_W-1:0];
      if (rd_more) begin
        rd_idx_reg <= rd_idx_reg + 1'b1;
      end
    end
  end

  wire logic [`CGOT_COL_W-1:0] raddr = copy_busy_reg ? rd_idx_reg[`CGOT_COL_W-1:0] : col_reg;
  wire logic        copy_wr = copy_busy_reg & wr_pend_reg;
  // no saved table yet means revert writes neutral entries
  wire cgot_coeff_t rev_src = saved_valid_reg ? sa : NEUTRAL;
  wire cgot_coeff_t bus_ent = hit_gain ?
                              cgot_coeff_t'{gain: wdata[15:0], offset: ua.offset} :
                              cgot_coeff_t'{gain: ua.gain, offset: wdata[15:0]};
  wire logic        u_we    = (copy_wr & ~copy_persist_reg) | coeff_wr;
  wire logic        s_we    = copy_wr & copy_persist_reg;
  wire logic [`CGOT_COL_W-1:0] u_waddr = copy_busy_reg ? wr_idx_reg : col_reg;
  wire cgot_coeff_t u_wdata = copy_busy_reg ? rev_src : bus_ent;

  cgot_mem u_user (
    .clk_i     (clk_i),
    .we_i      (u_we),
    .waddr_i   (u_waddr),
    .wdata_i   (u_wdata),
    .raddr_a_i (raddr),
    .rdata_a_o (ua),
    .raddr_b_i (pix_i.col),
    .rdata_b_o (ub)
  );

  // stands in for the retained store; the far side would back it with flash
  cgot_mem u_saved (
    .clk_i     (clk_i),
    .we_i      (s_we),
    .waddr_i   (wr_idx_reg),
    .wdata_i   (ua),
    .raddr_a_i (raddr),
    .rdata_a_o (sa),
    .raddr_b_i (pix_i.col),
    .rdata_b_o ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // pixel path, two cycles
  wire cgot_coeff_t fact = '{gain: `CGOT_GAIN_UNITY + 16'({lvl_reg, p1_reg.col}),
                             offset: `CGOT_OFS_ZERO};
  wire cgot_coeff_t coeff_sel = (mode_reg == CGOT_FACTORY) ? fact : ub;
  wire logic        corr_en = correction_on_i & ~is_calib;
  wire logic signed [17:0] sum = $signed({2'b00, p1_reg.data})
                                 + $signed({{2{coeff_sel.offset[15]}}, coeff_sel.offset});
  wire logic [16:0] sum_pos = sum[17] ? 17'h0_0000 : sum[16:0];
  wire logic [32:0] prod    = sum_pos * coeff_sel.gain;
  wire logic [20:0] scaled  = prod[`CGOT_GAIN_FRAC +: 21];
  wire logic [15:0] sat     = (|scaled[20:16]) ? `CGOT_PIX_MAX : scaled[15:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p1_reg  <= '0;
      lvl_reg <= 2'h0;
      pix_o   <= '0;
    end else begin
      p1_reg  <= pix_i;
      lvl_reg <= gain_level_i;
      pix_o   <= '{valid: p1_reg.valid, col: p1_reg.col,
                   data: corr_en ? sat : p1_reg.data};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_TBL_CALIB: assert property ((ack_o && (hit_gain || hit_ofs)) |-> is_calib)
    else $error("table access acknowledged outside calibration");
  AST_MODE_LEGAL: assert property (mode_reg inside {CGOT_FACTORY, CGOT_USER, CGOT_CALIB})
    else $error("mode selector holds an illegal value");
  AST_COL_RST: assert property ($past(rst_i) |-> col_reg == `CGOT_COL_RST)
    else $error("column selector not zero after reset");
  // read port follows the column, so the written entry shows two edges later
  AST_GAIN_COL: assert property (coeff_wr |-> ##2 ua == $past(u_wdata, 2))
    else $error("coefficient write missed the selected column");
  AST_OFS_STEP: assert property ((ack_o && we_i && hit_ofs) |-> !ofs_bad)
    else $error("offset off the step accepted");
  AST_OFS_ERR: assert property ((acc && we_i && hit_ofs && ofs_bad) |=> err_o && !ack_o)
    else $error("offset off the step not refused");
  AST_REV_NEUTRAL: assert property ((copy_wr && !copy_persist_reg && !saved_valid_reg)
                                    |-> u_wdata == NEUTRAL)
    else $error("revert without saved table wrote non-neutral data");
  AST_COPY_LEN: assert property ($rose(copy_busy_reg)
                                 |-> ##16 copy_busy_reg ##1 !copy_busy_reg)
    else $error("table copy length wrong");
  AST_PERSIST: assert property ((start && hit_per) |=> saved_valid_reg && copy_persist_reg)
    else $error("persist did not mark the saved table");
  AST_PIX_LAT: assert property (pix_i.valid |-> ##2 pix_o.valid)
    else $error("pixel latency not two cycles");
  AST_CAL_OFF: assert property ((is_calib && $stable(mode_reg)) |=> pix_o.data == $past(p1_reg.data))
    else $error("correction active in calibration");

  COV_REVERT: cover property (start && hit_rev);
  COV_PERSIST: cover property (start && hit_per);
  COV_ERR: cover property (err_o);
  COV_USER_PIX: cover property (pix_o.valid && mode_reg == CGOT_USER && corr_en);
endmodule : cgot_top

// ===== sim/cgot_host.sv
`timescale 1ns/10ps
`include "cgot_params.svh"
module cgot_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [3:0]       sel_o,
  output logic [7:0]       adr_o,
  output logic [31:0]      dat_o,
  output logic             stream_o
);
  initial begin
    cyc_o    = 1'b0;
    stb_o    = 1'b0;
    we_o     = 1'b0;
    sel_o    = 4'h0;
    adr_o    = 8'h00;
    dat_o    = 32'h0000_0000;
    stream_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic stream(input logic on);
    @(posedge clk_i);
    stream_o <= on;
  endtask : stream
  // one classic cycle; no latency assumed, only a bounded wait
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e, output logic to);
    int n;
    if (w && a == `CGOT_ADR_MODE && d[1:0] != 2'h2) begin
      stream(1'b0);
    end
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    sel_o <= 4'hF;
    adr_o <= a;
    dat_o <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(ack_i || err_i) && n < 60);
    q  = dat_i;
    e  = err_i;
    to = !(ack_i || err_i);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // released bus shows a changing pattern, not the old word
    dat_o <= ~d;
  endtask : acc
endmodule : cgot_host

// ===== sim/tb_top.sv
`timescale 1ns/10ps
`include "cgot_params.svh"
module tb_top;
  import cgot_pkg::*;
  typedef struct packed {
    logic        we;
    logic [7:0]  adr;
    logic [31:0] wd;
    logic        er;
    logic [31:0] rd;
  } cgot_row_t;
  logic clk_i, rst_i, cyc, stb, we, ack, err, strm, con;
  logic [3:0]  sel;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat;
  logic [1:0]  gl;
  logic [3:0]  pcol;
  logic [15:0] praw;
  cgot_pix_t   pix, pout;
  int          mismatches, n_checks;
  cgot_row_t   rows [0:26];
  assign pix = {strm, pcol, praw};
  cgot_host host (.clk_i(clk_i), .ack_i(ack), .err_i(err), .dat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .sel_o(sel), .adr_o(adr), .dat_o(wdat), .stream_o(strm));
  cgot_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .sel_i(sel), .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err),
    .correction_on_i(con), .gain_level_i(gl), .pix_i(pix), .pix_o(pout));
  //////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input cgot_row_t r);
    logic [31:0] q;
    logic        e, to;
    host.acc(r.we, r.adr, r.wd, q, e, to);
    if (to) begin
      mismatches++;
      report_and_stop();
    end else begin
      check({31'h0000_0000, e}, {31'h0000_0000, r.er});
      check(q, r.rd);
    end
  endtask : bus
  function automatic cgot_row_t mk(int w, logic [7:0] a, logic [31:0] d, int e,
                                   logic [31:0] r);
    return {w[0], a, d, e[0], r};
  endfunction : mk
  // pipeline is two deep; four cycles of steady input leave margin
  task automatic pchk(input logic [15:0] raw, input logic [15:0] exp);
    @(posedge clk_i);
    praw <= raw;
    repeat (4) @(posedge clk_i);
    check({11'h000, pout.valid, pout.col, pout.data}, {11'h000, 1'b1, pcol, exp});
  endtask : pchk
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1;
    con = 1'b1;
    gl = 2'h0;
    pcol = 4'h5;
    praw = 16'h0000;
    mismatches = 0;
    n_checks = 0;
    rows[0]  = mk(0, `CGOT_ADR_MODE, 0, 0, 32'h0000_0000);
    rows[1]  = mk(0, `CGOT_ADR_COL, 0, 0, 32'h0000_0000);
    rows[2]  = mk(0, `CGOT_ADR_GAIN, 0, 1, 32'h0000_0000);
    rows[3]  = mk(1, `CGOT_ADR_MODE, 32'h0000_0003, 1, 0);
    rows[4]  = mk(1, `CGOT_ADR_MODE, 32'h0000_0002, 0, 0);
    rows[5]  = mk(0, `CGOT_ADR_MODE, 0, 0, 32'h0000_0002);
    rows[6]  = mk(0, `CGOT_ADR_GAIN, 0, 0, 32'h0000_1000);
    rows[7]  = mk(1, `CGOT_ADR_COL, 32'h0000_0005, 0, 0);
    rows[8]  = mk(1, `CGOT_ADR_GAIN, 32'h0000_2000, 0, 0);
    rows[9]  = mk(1, `CGOT_ADR_OFS, 32'h0000_0021, 1, 0);
    rows[10] = mk(1, `CGOT_ADR_OFS, 32'h0000_0040, 0, 0);
    rows[11] = mk(0, `CGOT_ADR_GAIN, 0, 0, 32'h0000_2000);
    rows[12] = mk(0, `CGOT_ADR_OFS, 0, 0, 32'h0000_0040);
    rows[13] = mk(1, `CGOT_ADR_COL, 32'h0000_0000, 0, 0);
    rows[14] = mk(0, `CGOT_ADR_GAIN, 0, 0, 32'h0000_1000);
    rows[15] = mk(1, `CGOT_ADR_PERSIST, 32'h0000_0001, 0, 0);
    rows[16] = mk(1, `CGOT_ADR_COL, 32'h0000_0005, 0, 0);
    rows[17] = mk(1, `CGOT_ADR_GAIN, 32'h0000_3000, 0, 0);
    rows[18] = mk(1, `CGOT_ADR_REVERT, 32'h0000_0001, 0, 0);
    rows[19] = mk(0, `CGOT_ADR_GAIN, 0, 0, 32'h0000_2000);
    rows[20] = mk(1, `CGOT_ADR_GAIN, 32'h0000_3000, 0, 0);
    rows[21] = mk(1, `CGOT_ADR_PERSIST, 32'h0000_0001, 0, 0);
    rows[22] = mk(1, `CGOT_ADR_REVERT, 32'h0000_0001, 0, 0);
    rows[23] = mk(0, `CGOT_ADR_GAIN, 0, 0, 32'h0000_3000);
    rows[24] = mk(0, `CGOT_ADR_PERSIST, 0, 0, 32'h0000_0000);
    rows[25] = mk(0, 8'h1C, 0, 1, 32'h0000_0000);
    rows[26] = mk(0, `CGOT_ADR_STATUS, 0, 0, 32'h0000_000E);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // first request is simply held while the boot copy runs
    foreach (rows[i]) bus(rows[i]);
    // sticky error bits clear on a one; the saved flag stays
    bus(mk(1, `CGOT_ADR_STATUS, 32'h0000_000C, 0, 0));
    bus(mk(0, `CGOT_ADR_STATUS, 0, 0, 32'h0000_0002));
    host.stream(1'b1);
    pchk(16'h0100, 16'h0100);
    bus(mk(1, `CGOT_ADR_MODE, 32'h0000_0001, 0, 0));
    host.stream(1'b1);
    pchk(16'h0100, 16'h03C0);
    gl <= 2'h3;
    pchk(16'h0100, 16'h03C0);
    bus(mk(1, `CGOT_ADR_MODE, 32'h0000_0000, 0, 0));
    host.stream(1'b1);
    gl <= 2'h1;
    pchk(16'h1000, 16'h1015);
    gl <= 2'h2;
    pchk(16'h1000, 16'h1025);
    con <= 1'b0;
    pchk(16'h1000, 16'h1000);
    con <= 1'b1;
    // mid-run reset drops the saved table, so the user table comes back neutral
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    check({11'h000, pout}, 32'h0000_0000);
    rst_i <= 1'b0;
    bus(mk(0, `CGOT_ADR_MODE, 0, 0, 32'h0000_0000));
    bus(mk(0, `CGOT_ADR_COL, 0, 0, 32'h0000_0000));
    bus(mk(0, `CGOT_ADR_STATUS, 0, 0, 32'h0000_0000));
    bus(mk(1, `CGOT_ADR_MODE, 32'h0000_0002, 0, 0));
    bus(mk(1, `CGOT_ADR_COL, 32'h0000_0005, 0, 0));
    bus(mk(0, `CGOT_ADR_GAIN, 0, 0, 32'h0000_1000));
    report_and_stop();
  end
endmodule : tb_top
